// [rtl/rnc_core.sv]
// Function
// - left rotate turns the 48-bit pair left; no bit is lost
// - normalize shifts left until bit 1 differs from sign, or count runs out
// - normalize subtracts the shifts done from the index register
// - a zero pair with a count of 48 or more shifts 48 places, so 48 leaves the index
// - halt steps the program counter, lights the lamp and stops
// - halt ends on idle then run/step, or an interrupt in run
// - halt and breakpoint tests trap to 40B in user mode
// - a trap under execute indirect saves the outermost address
// - no-operation changes nothing and ignores indirect and index bits
// - execute indirect runs its word then continues after itself
// - a branch run by execute indirect goes to its own target
// - a skip run by execute indirect skips relative to execute indirect
// - chains are followed to any depth, interruptible in user and monitor
// - breakpoint tests skip if any tested switch is reset
// - test-and-clear skips if overflow off, else clears it
// - signal skip 20001B tests and clears overflow outside user mode
// - test-only keeps overflow, skips when off
// - record exponent overflow sets flag when index bits 14, 15 differ
// - output mode 20100B records exponent overflow outside user mode
// - reset overflow clears the flag in any mode, unless a hardware set comes in the same cycle
// - output mode 20001B clears the flag outside user mode
// - shift count is unsigned, zero shifts nothing, above 48 clamps
// - address bits 10,11 select plain, rotate or normalize
`include "rnc_defs.svh"

module rnc_core #(
  parameter int SHIFT_MAX = `RNC_SHIFT_MAX
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // instruction issue
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input rnc_pkg::rnc_issue_s issue_i,
  // effective word fetch
  output logic fetch_req_o,
  output logic [13:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  input wire logic [23:0] fetch_word_i,
  input wire logic [13:0] fetch_eff_i,
  // completion
  output logic done_o,
  output rnc_pkg::rnc_result_s result_o,
  // console and system
  input rnc_pkg::rnc_switch_e run_switch_i,
  input wire logic [3:0] breakpoint_i,
  input wire logic irq_active_i,
  input wire logic ovf_set_i,
  output logic halt_lamp_o,
  output logic resume_o,
  output logic resume_irq_o,
  output logic overflow_flag_o
);

  // refuse a SHIFT_MAX below 1 or above RNC_SHIFT_MAX
  if (SHIFT_MAX < 1 || SHIFT_MAX > `RNC_SHIFT_MAX) begin
    $error("SHIFT_MAX out of range");
  end

  localparam logic [8:0] CNT_CAP = 9'(SHIFT_MAX);

  rnc_pkg::rnc_state_e state_reg;
  rnc_pkg::rnc_mode_e mode_reg;
  logic [47:0] ab_reg;
  logic [23:0] x_reg;
  logic [8:0] cnt_reg;
  logic [8:0] done_reg;
  logic norm_reg;
  logic [13:0] base_reg;
  logic [13:0] fetch_addr_reg;
  logic ovf_reg;
  logic idle_seen_reg;

  // word under decode: new issue or fetched execute-indirect word
  logic take_issue;
  logic take_fetch;
  logic take;
  logic [23:0] w;
  logic [13:0] w_eff;
  logic [13:0] w_base;
  logic w_user;
  logic [23:0] w_x;
  logic [5:0] op;
  logic [14:0] adr;
  logic [1:0] method;
  logic [8:0] cnt_raw;
  logic [3:0] bpt_mask;

  assign take_issue = issue_valid_i && state_reg == rnc_pkg::RNC_ST_IDLE;
  assign take_fetch = fetch_valid_i && state_reg == rnc_pkg::RNC_ST_FETCH;
  assign take = take_issue || take_fetch;
  assign w = take_fetch ? fetch_word_i : issue_i.word;
  assign w_eff = take_fetch ? fetch_eff_i : issue_i.eff;
  // base stays the outermost execute-indirect address
  assign w_base = take_fetch ? base_reg : issue_i.pc;
  assign w_user = take_fetch ? (mode_reg == rnc_pkg::RNC_MODE_USER)
                             : (issue_i.mode == rnc_pkg::RNC_MODE_USER);
  assign w_x = take_fetch ? x_reg : issue_i.x;
  assign op = w[`RNC_OP_HI:`RNC_OP_LO];
  assign adr = w[14:0];
  assign method = w_eff[`RNC_MTH_HI:`RNC_MTH_LO];
  assign cnt_raw = {5'h0, w_eff[`RNC_CNT_HI:`RNC_CNT_LO]} == 14'h0 ? 9'h0
                 : w_eff[`RNC_CNT_HI:`RNC_CNT_LO];
  assign bpt_mask = {adr[5], adr[6], adr[7], adr[8]};

  rnc_pkg::rnc_kind_e kind;
  logic ovf_clr;
  logic ovf_rec;

  always_comb begin
    kind = rnc_pkg::RNC_K_FOREIGN;
    ovf_clr = 1'b0;
    ovf_rec = 1'b0;
    case (op)
      `RNC_OP_LEFT: begin
        if (method == `RNC_SH_CYCLE || method == `RNC_SH_NORM) begin
          kind = rnc_pkg::RNC_K_SHIFT;
        end
      end
      `RNC_OP_EXU: kind = rnc_pkg::RNC_K_EXU;
      `RNC_OP_NOP: kind = rnc_pkg::RNC_K_SEQ;
      `RNC_OP_HALT: begin
        kind = w_user ? rnc_pkg::RNC_K_TRAP : rnc_pkg::RNC_K_HALT;
      end
      `RNC_OP_OVF: begin
        case (adr)
          `RNC_AD_OVT: begin
            kind = ovf_reg ? rnc_pkg::RNC_K_SEQ : rnc_pkg::RNC_K_SKIP;
            ovf_clr = ovf_reg;
          end
          `RNC_AD_OTO: begin
            kind = ovf_reg ? rnc_pkg::RNC_K_SEQ : rnc_pkg::RNC_K_SKIP;
          end
          `RNC_AD_REO: begin
            kind = rnc_pkg::RNC_K_SEQ;
            ovf_rec = w_x[`RNC_X_EXP_HI] ^ w_x[`RNC_X_EXP_LO];
          end
          `RNC_AD_ROV: begin
            kind = rnc_pkg::RNC_K_SEQ;
            ovf_clr = 1'b1;
          end
          default: kind = rnc_pkg::RNC_K_FOREIGN;
        endcase
      end
      `RNC_OP_SKS: begin
        if ((adr & ~`RNC_AD_BPT_MASK) == `RNC_AD_BPT_BASE && |bpt_mask) begin
          if (w_user) begin
            kind = rnc_pkg::RNC_K_TRAP;
          end else if (|(bpt_mask & ~breakpoint_i)) begin
            kind = rnc_pkg::RNC_K_SKIP;
          end else begin
            kind = rnc_pkg::RNC_K_SEQ;
          end
        end else if (adr == `RNC_AD_SIG_OVF && !w_user) begin
          kind = ovf_reg ? rnc_pkg::RNC_K_SEQ : rnc_pkg::RNC_K_SKIP;
          ovf_clr = ovf_reg;
        end
      end
      `RNC_OP_EOM: begin
        if (adr == `RNC_AD_EOM_REO && !w_user) begin
          kind = rnc_pkg::RNC_K_SEQ;
          ovf_rec = w_x[`RNC_X_EXP_HI] ^ w_x[`RNC_X_EXP_LO];
        end else if (adr == `RNC_AD_EOM_ROV && !w_user) begin
          kind = rnc_pkg::RNC_K_SEQ;
          ovf_clr = 1'b1;
        end
      end
      default: kind = rnc_pkg::RNC_K_FOREIGN;
    endcase
  end

  // shift step
  logic norm_stop;
  logic shift_end;
  logic [47:0] ab_step;

  assign norm_stop = norm_reg && (ab_reg[46] != ab_reg[47]);
  assign shift_end = cnt_reg == 9'h0 || norm_stop;
  assign ab_step = norm_reg ? {ab_reg[46:0], 1'b0}
                            : {ab_reg[46:0], ab_reg[47]};

  logic abort_chain;
  assign abort_chain = state_reg == rnc_pkg::RNC_ST_FETCH && !fetch_valid_i
                    && irq_active_i && mode_reg != rnc_pkg::RNC_MODE_NORMAL;

  // sequencing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= rnc_pkg::RNC_ST_IDLE;
      mode_reg <= rnc_pkg::RNC_MODE_NORMAL;
      base_reg <= 14'h0;
      fetch_addr_reg <= 14'h0;
      idle_seen_reg <= 1'b0;
    end else begin
      case (state_reg)
        rnc_pkg::RNC_ST_IDLE: begin
          if (take_issue) begin
            base_reg <= issue_i.pc;
            mode_reg <= issue_i.mode;
          end
        end
        rnc_pkg::RNC_ST_SHIFT: begin
          if (shift_end) begin
            state_reg <= rnc_pkg::RNC_ST_IDLE;
          end
        end
        rnc_pkg::RNC_ST_FETCH: begin
          if (abort_chain) begin
            state_reg <= rnc_pkg::RNC_ST_IDLE;
          end
        end
        rnc_pkg::RNC_ST_HALTED: begin
          if (run_switch_i == rnc_pkg::RNC_SW_IDLE) begin
            idle_seen_reg <= 1'b1;
          end else if (idle_seen_reg
                       || (run_switch_i == rnc_pkg::RNC_SW_RUN
                           && irq_active_i)) begin
            state_reg <= rnc_pkg::RNC_ST_IDLE;
          end
        end
        default: state_reg <= rnc_pkg::RNC_ST_IDLE;
      endcase
      if (take) begin
        case (kind)
          rnc_pkg::RNC_K_SHIFT: state_reg <= rnc_pkg::RNC_ST_SHIFT;
          rnc_pkg::RNC_K_EXU: begin
            state_reg <= rnc_pkg::RNC_ST_FETCH;
            fetch_addr_reg <= w_eff;
          end
          rnc_pkg::RNC_K_HALT: begin
            state_reg <= rnc_pkg::RNC_ST_HALTED;
            idle_seen_reg <= 1'b0;
          end
          default: state_reg <= rnc_pkg::RNC_ST_IDLE;
        endcase
      end
    end
  end

  // shift engine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ab_reg <= 48'h0;
      x_reg <= 24'h0;
      cnt_reg <= 9'h0;
      done_reg <= 9'h0;
      norm_reg <= 1'b0;
    end else if (take_issue) begin
      ab_reg <= {issue_i.a, issue_i.b};
      x_reg <= issue_i.x;
      cnt_reg <= cnt_raw > CNT_CAP ? CNT_CAP : cnt_raw;
      done_reg <= 9'h0;
      norm_reg <= method == `RNC_SH_NORM;
    end else if (take_fetch) begin
      cnt_reg <= cnt_raw > CNT_CAP ? CNT_CAP : cnt_raw;
      done_reg <= 9'h0;
      norm_reg <= method == `RNC_SH_NORM;
    end else if (state_reg == rnc_pkg::RNC_ST_SHIFT && !shift_end) begin
      ab_reg <= ab_step;
      cnt_reg <= cnt_reg - 9'h1;
      done_reg <= done_reg + 9'h1;
    end
  end

  // overflow bit, a hardware set wins over a clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
    end else if (ovf_set_i || (take && ovf_rec)) begin
      ovf_reg <= 1'b1;
    end else if (take && ovf_clr) begin
      ovf_reg <= 1'b0;
    end
  end

  // results
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      result_o <= '0;
      resume_o <= 1'b0;
      resume_irq_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      resume_o <= 1'b0;
      resume_irq_o <= 1'b0;
      if (state_reg == rnc_pkg::RNC_ST_HALTED
          && run_switch_i != rnc_pkg::RNC_SW_IDLE) begin
        if (idle_seen_reg) begin
          resume_o <= 1'b1;
        end else if (run_switch_i == rnc_pkg::RNC_SW_RUN && irq_active_i) begin
          resume_o <= 1'b1;
          resume_irq_o <= 1'b1;
        end
      end
      if (state_reg == rnc_pkg::RNC_ST_SHIFT && shift_end) begin
        done_o <= 1'b1;
        result_o.act <= rnc_pkg::RNC_ACT_SEQ;
        result_o.next_pc <= base_reg + 14'h1;
        result_o.save_pc <= base_reg;
        result_o.a <= ab_reg[47:24];
        result_o.b <= ab_reg[23:0];
        result_o.x <= x_reg - {15'h0, done_reg};
        result_o.ab_we <= 1'b1;
        result_o.x_we <= norm_reg;
      end else if (abort_chain) begin
        done_o <= 1'b1;
        result_o <= '0;
        result_o.act <= rnc_pkg::RNC_ACT_INTR;
        result_o.next_pc <= base_reg;
        result_o.save_pc <= base_reg;
      end else if (take && kind != rnc_pkg::RNC_K_SHIFT
                   && kind != rnc_pkg::RNC_K_EXU) begin
        done_o <= 1'b1;
        result_o <= '0;
        result_o.save_pc <= w_base;
        case (kind)
          rnc_pkg::RNC_K_SKIP: begin
            result_o.act <= rnc_pkg::RNC_ACT_SKIP;
            result_o.next_pc <= w_base + 14'h2;
          end
          rnc_pkg::RNC_K_TRAP: begin
            result_o.act <= rnc_pkg::RNC_ACT_TRAP;
            result_o.next_pc <= `RNC_TRAP_ADDR;
          end
          rnc_pkg::RNC_K_FOREIGN: begin
            result_o.act <= rnc_pkg::RNC_ACT_FOREIGN;
            result_o.next_pc <= w_base + 14'h1;
          end
          rnc_pkg::RNC_K_HALT: begin
            result_o.act <= rnc_pkg::RNC_ACT_HALT;
            result_o.next_pc <= w_base + 14'h1;
          end
          default: begin
            result_o.act <= rnc_pkg::RNC_ACT_SEQ;
            result_o.next_pc <= w_base + 14'h1;
          end
        endcase
      end
    end
  end

  assign issue_ready_o = state_reg == rnc_pkg::RNC_ST_IDLE;
  assign fetch_req_o = state_reg == rnc_pkg::RNC_ST_FETCH;
  assign fetch_addr_o = fetch_addr_reg;
  assign halt_lamp_o = state_reg == rnc_pkg::RNC_ST_HALTED;
  assign overflow_flag_o = ovf_reg;

endmodule

// [rtl/rnc_defs.svh]
`ifndef RNC_DEFS_SVH
`define RNC_DEFS_SVH

// opcode field, instruction bits 3..8
`define RNC_OP_HALT 6'h00
`define RNC_OP_EOM 6'h02
`define RNC_OP_EXU 6'h13
`define RNC_OP_NOP 6'h10
`define RNC_OP_OVF 6'h12
`define RNC_OP_SKS 6'h20
`define RNC_OP_LEFT 6'h37

// address field codes, instruction bits 9..23
`define RNC_AD_OVT 15'h0041
`define RNC_AD_OTO 15'h0040
`define RNC_AD_REO 15'h0008
`define RNC_AD_ROV 15'h0001
`define RNC_AD_SIG_OVF 15'h2001
`define RNC_AD_EOM_REO 15'h2040
`define RNC_AD_EOM_ROV 15'h2001
`define RNC_AD_BPT_BASE 15'h2000
`define RNC_AD_BPT_MASK 15'h01E0

// shift method, effective address bits 10,11
`define RNC_SH_CYCLE 2'b10
`define RNC_SH_NORM 2'b01

// field positions
`define RNC_OP_HI 20
`define RNC_OP_LO 15
`define RNC_MTH_HI 13
`define RNC_MTH_LO 12
`define RNC_CNT_HI 8
`define RNC_CNT_LO 0
`define RNC_X_EXP_HI 9
`define RNC_X_EXP_LO 8

// limits and fixed addresses
`define RNC_SHIFT_MAX 48
`define RNC_TRAP_ADDR 14'h0020

`endif

// [rtl/rnc_pkg.sv]
package rnc_pkg;

  typedef enum logic [1:0] {
    RNC_MODE_NORMAL = 2'b00,
    RNC_MODE_MONITOR = 2'b01,
    RNC_MODE_USER = 2'b10
  } rnc_mode_e;

  typedef enum logic [1:0] {
    RNC_SW_IDLE = 2'b00,
    RNC_SW_RUN = 2'b01,
    RNC_SW_STEP = 2'b10
  } rnc_switch_e;

  typedef enum logic [1:0] {
    RNC_ST_IDLE = 2'b00,
    RNC_ST_SHIFT = 2'b01,
    RNC_ST_FETCH = 2'b10,
    RNC_ST_HALTED = 2'b11
  } rnc_state_e;

  typedef enum logic [2:0] {
    RNC_ACT_SEQ = 3'b000,
    RNC_ACT_SKIP = 3'b001,
    RNC_ACT_TRAP = 3'b010,
    RNC_ACT_FOREIGN = 3'b011,
    RNC_ACT_HALT = 3'b100,
    RNC_ACT_INTR = 3'b101
  } rnc_act_e;

  typedef enum logic [2:0] {
    RNC_K_SEQ = 3'b000,
    RNC_K_SKIP = 3'b001,
    RNC_K_TRAP = 3'b010,
    RNC_K_FOREIGN = 3'b011,
    RNC_K_HALT = 3'b100,
    RNC_K_EXU = 3'b101,
    RNC_K_SHIFT = 3'b110
  } rnc_kind_e;

  typedef struct packed {
    logic [23:0] word;
    logic [13:0] pc;
    logic [13:0] eff;
    rnc_mode_e mode;
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] x;
  } rnc_issue_s;

  typedef struct packed {
    rnc_act_e act;
    logic [13:0] next_pc;
    logic [13:0] save_pc;
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] x;
    logic ab_we;
    logic x_we;
  } rnc_result_s;

endpackage

// [dv/rnc_core_sva.sv]
`include "rnc_defs.svh"
module rnc_core_sva #(
  parameter int SHIFT_MAX = 48
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // issue and fetch
  input wire logic issue_valid_i,
  input wire logic issue_ready_o,
  input rnc_pkg::rnc_issue_s issue_i,
  input wire logic fetch_req_o,
  input wire logic [13:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  // completion and console
  input wire logic done_o,
  input rnc_pkg::rnc_result_s result_o,
  input wire logic irq_active_i,
  input wire logic ovf_set_i,
  input wire logic halt_lamp_o,
  input wire logic resume_o,
  input wire logic overflow_flag_o
);
  logic take;
  logic ovf;
  logic usr;
  logic [5:0] op;
  logic [14:0] ad;
  logic [13:0] pc1;
  rnc_pkg::rnc_act_e act;
  assign take = issue_valid_i && issue_ready_o;
  assign op = issue_i.word[20:15];
  assign ovf = take && op == `RNC_OP_OVF && !ovf_set_i;
  assign usr = issue_i.mode == rnc_pkg::RNC_MODE_USER;
  assign ad = issue_i.word[14:0];
  assign pc1 = issue_i.pc + 14'h0001;
  assign act = result_o.act;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_nop;
    take && op == `RNC_OP_NOP |=> done_o && act == rnc_pkg::RNC_ACT_SEQ
      && result_o.next_pc == $past(pc1) && !result_o.ab_we && !result_o.x_we;
  endproperty
  a_nop: assert property (p_nop) else $error("nop result wrong");
  property p_halt;
    take && op == `RNC_OP_HALT && !usr |=> done_o
      && act == rnc_pkg::RNC_ACT_HALT && result_o.next_pc == $past(pc1)
      && halt_lamp_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  property p_trap;
    take && op == `RNC_OP_HALT && usr |=> done_o
      && act == rnc_pkg::RNC_ACT_TRAP && result_o.next_pc == 14'h0020
      && result_o.save_pc == $past(issue_i.pc);
  endproperty
  a_trap: assert property (p_trap) else $error("trap wrong");
  property p_ovt;
    ovf && ad == `RNC_AD_OVT |=> !overflow_flag_o && act ==
      ($past(overflow_flag_o) ? rnc_pkg::RNC_ACT_SEQ : rnc_pkg::RNC_ACT_SKIP);
  endproperty
  a_ovt: assert property (p_ovt) else $error("test clear wrong");
  property p_oto;
    ovf && ad == `RNC_AD_OTO |=> $stable(overflow_flag_o) && act ==
      (overflow_flag_o ? rnc_pkg::RNC_ACT_SEQ : rnc_pkg::RNC_ACT_SKIP);
  endproperty
  a_oto: assert property (p_oto) else $error("test keep wrong");
  property p_reo;
    ovf && ad == `RNC_AD_REO && issue_i.x[9] != issue_i.x[8]
      |=> overflow_flag_o;
  endproperty
  a_reo: assert property (p_reo) else $error("record wrong");
  property p_keep;
    $changed(overflow_flag_o) && !$past(ovf_set_i) |-> done_o;
  endproperty
  a_keep: assert property (p_keep) else $error("flag drift");
  property p_resume;
    resume_o |-> !halt_lamp_o && $past(halt_lamp_o);
  endproperty
  a_resume: assert property (p_resume) else $error("resume bad");
  property p_fetch;
    fetch_req_o && !fetch_valid_i && !irq_active_i
      |=> fetch_req_o && $stable(fetch_addr_o);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch dropped");
endmodule

bind rnc_core rnc_core_sva #(.SHIFT_MAX(SHIFT_MAX)) u_rnc_core_sva (
  .clk_i, .rst_i, .issue_valid_i, .issue_ready_o, .issue_i, .fetch_req_o,
  .fetch_addr_o, .fetch_valid_i, .done_o, .result_o, .irq_active_i,
  .ovf_set_i, .halt_lamp_o, .resume_o, .overflow_flag_o
);

// [dv/rnc_mem_model.sv]
module rnc_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fetch port
  input wire logic req_i,
  input wire logic [13:0] addr_i,
  input wire logic [3:0] lat_i,
  output logic valid_o,
  output logic [23:0] word_o,
  output logic [13:0] eff_o
);
  logic [23:0] word_mem [16];
  logic [13:0] eff_mem [16];
  logic [3:0] wait_reg;
  // idle lines show the inverse of their last value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      word_o <= 24'h000000;
      eff_o <= 14'h0000;
      wait_reg <= 4'h0;
    end else begin
      valid_o <= 1'b0;
      word_o <= ~word_o;
      eff_o <= ~eff_o;
      if (!req_i) begin
        wait_reg <= 4'h0;
      end else if (!valid_o && wait_reg >= lat_i) begin
        valid_o <= 1'b1;
        word_o <= word_mem[addr_i[3:0]];
        eff_o <= eff_mem[addr_i[3:0]];
        wait_reg <= 4'h0;
      end else if (!valid_o) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// [dv/rotate_normalize_control_overflow_tb.sv]
`include "rnc_defs.svh"
module rotate_normalize_control_overflow_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic iss_valid = 1'b0;
  logic irq = 1'b0;
  logic ovf_set = 1'b0;
  logic [3:0] bpt = 4'hF;
  logic [3:0] lat = 4'h0;
  logic [3:0] sel;
  logic [8:0] cnt;
  rnc_pkg::rnc_switch_e sw = rnc_pkg::RNC_SW_RUN;
  rnc_pkg::rnc_mode_e md = rnc_pkg::RNC_MODE_NORMAL;
  rnc_pkg::rnc_issue_s iss = '0;
  rnc_pkg::rnc_result_s res;
  rnc_pkg::rnc_result_s result_o;
  logic issue_ready_o, fetch_req_o, fv, done_o, halt_lamp_o, resume_o;
  logic resume_irq_o, overflow_flag_o;
  logic [13:0] fetch_addr_o, fe;
  logic [23:0] fw, w;
  logic [15:0] rnd = 16'h3BEC;
  logic [47:0] p;
  logic [71:0] ex;
  int miscompares = 0;
  int checks_done = 0;
  int took, n;
  int cyc = 0;

  always #20 clk_i = ~clk_i;

  rnc_core u_rnc_core (.clk_i, .rst_i, .issue_valid_i(iss_valid),
    .issue_ready_o, .issue_i(iss), .fetch_req_o, .fetch_addr_o,
    .fetch_valid_i(fv), .fetch_word_i(fw), .fetch_eff_i(fe), .done_o,
    .result_o, .run_switch_i(sw), .breakpoint_i(bpt), .irq_active_i(irq),
    .ovf_set_i(ovf_set), .halt_lamp_o, .resume_o, .resume_irq_o,
    .overflow_flag_o);
  rnc_mem_model u_rnc_mem_model (.clk_i, .rst_i, .req_i(fetch_req_o),
    .addr_i(fetch_addr_o), .lat_i(lat), .valid_o(fv), .word_o(fw),
    .eff_o(fe));

  function automatic logic [15:0] nxt();
    rnd = {rnd[14:0], ^(rnd & 16'hB400)};
    return rnd;
  endfunction
  function automatic logic [23:0] mk(input logic [5:0] op,
                                     input logic [14:0] ad);
    return {3'h0, op, ad};
  endfunction
  function automatic logic [47:0] rot(input logic [47:0] v, input int k);
    return (v << k) | (v >> (48 - k));
  endfunction
  function automatic logic [71:0] normalize_count_down(input logic [47:0] v, input int c,
                                      input logic [23:0] x);
    int k;
    k = 0;
    while (k < c && k < 48 && v[46] == v[47]) begin
      v = v << 1;
      k++;
    end
    return {v, x - 24'(k)};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic run_op(input logic [23:0] wd, input logic [13:0] e);
    @(negedge clk_i);
    iss.word = wd;
    iss.eff = e;
    iss.mode = md;
    iss.pc = 14'(nxt());
    iss_valid = 1'b1;
    while (issue_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    iss_valid = 1'b0;
    took = 1;
    while (done_o !== 1'b1 && took < 200) begin
      @(negedge clk_i);
      took++;
    end
    res = result_o;
  endtask
  task automatic ovf_op(input logic [14:0] ad, input rnc_pkg::rnc_act_e act,
                        input logic flag);
    run_op(mk(ad[14] ? `RNC_OP_SKS : `RNC_OP_OVF, {1'b0, ad[13:0]}), 14'h0);
    check(res.act, act);
    check(overflow_flag_o, flag);
    check(res.next_pc, 14'(iss.pc + ((act == rnc_pkg::RNC_ACT_SKIP) ? 2 : 1)));
  endtask
  task automatic set_ovf();
    @(negedge clk_i);
    ovf_set = 1'b1;
    @(negedge clk_i);
    ovf_set = 1'b0;
  endtask
  task automatic wait_resume();
    took = 0;
    while (resume_o !== 1'b1 && took < 50) begin
      @(negedge clk_i);
      took++;
    end
    check(took < 50, 1'b1);
  endtask

  initial begin
    for (int i = 0; i < 16; i++) begin
      u_rnc_mem_model.word_mem[i] = 24'h000000;
      u_rnc_mem_model.eff_mem[i] = 14'h0000;
    end
    u_rnc_mem_model.word_mem[1] = mk(`RNC_OP_OVF, `RNC_AD_OVT);
    u_rnc_mem_model.word_mem[2] = mk(`RNC_OP_EXU, 15'h0003);
    u_rnc_mem_model.eff_mem[2] = 14'h0003;
    u_rnc_mem_model.word_mem[4] = mk(6'h01, 15'h0123);
    u_rnc_mem_model.eff_mem[4] = 14'h0123;
    u_rnc_mem_model.word_mem[5] = mk(`RNC_OP_NOP, 15'h0000);
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    iss.a = 24'({nxt(), nxt()});
    iss.b = 24'({nxt(), nxt()});
    run_op({3'b010, `RNC_OP_NOP, 15'h4000}, 14'h3FFF);
    check(res.next_pc, 14'(iss.pc + 14'h0001));
    check({res.ab_we, res.x_we}, 2'b00);
    check(took, 1);
    $display("nop test done");
    set_ovf();
    ovf_op(`RNC_AD_OTO, rnc_pkg::RNC_ACT_SEQ, 1'b1);
    ovf_op(`RNC_AD_OVT, rnc_pkg::RNC_ACT_SEQ, 1'b0);
    ovf_op(`RNC_AD_OVT, rnc_pkg::RNC_ACT_SKIP, 1'b0);
    ovf_op(`RNC_AD_OTO, rnc_pkg::RNC_ACT_SKIP, 1'b0);
    iss.x = 24'h000300;
    ovf_op(`RNC_AD_REO, rnc_pkg::RNC_ACT_SEQ, 1'b0);
    iss.x = 24'h000100;
    ovf_op(`RNC_AD_REO, rnc_pkg::RNC_ACT_SEQ, 1'b1);
    md = rnc_pkg::RNC_MODE_USER;
    ovf_op(`RNC_AD_ROV, rnc_pkg::RNC_ACT_SEQ, 1'b0);
    md = rnc_pkg::RNC_MODE_MONITOR;
    run_op(mk(`RNC_OP_EOM, `RNC_AD_EOM_REO), 14'h0);
    check(overflow_flag_o, 1'b1);
    ovf_op(`RNC_AD_SIG_OVF | 15'h4000, rnc_pkg::RNC_ACT_SEQ, '0);
    ovf_op(`RNC_AD_SIG_OVF | 15'h4000, rnc_pkg::RNC_ACT_SKIP, '0);
    set_ovf();
    run_op(mk(`RNC_OP_EOM, `RNC_AD_EOM_ROV), 14'h0);
    check(overflow_flag_o, 1'b0);
    md = rnc_pkg::RNC_MODE_NORMAL;
    $display("overflow test done");
    iss.a = 24'hE63570;
    iss.b = 24'h70DDD3;
    run_op(mk(`RNC_OP_LEFT, 15'h2009), 14'h2009);
    check({res.a, res.b}, {24'h6AE0E1, 24'hBBA7CC});
    for (int i = 0; i < 6; i++) begin
      cnt = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'(nxt());
      p = {nxt(), nxt(), nxt()};
      {iss.a, iss.b} = p;
      run_op(mk(`RNC_OP_LEFT, {3'h2, 3'h0, cnt}), {2'b10, 3'h0, cnt});
      n = (cnt > 48) ? 48 : int'(cnt);
      check({res.a, res.b}, rot(p, n));
      check({res.ab_we, res.x_we}, 2'b10);
      check(took, n + 2);
    end
    $display("rotate test done");
    {iss.a, iss.b, iss.x} = {24'h000800, 48'h0};
    run_op(mk(`RNC_OP_LEFT, 15'h101E), 14'h101E);
    check(res.x, 24'hFFFFF5);
    iss.x = 24'h000100;
    {iss.a, iss.b} = 48'h0;
    run_op(mk(`RNC_OP_LEFT, 15'h11FF), 14'h11FF);
    check(res.x, 24'h0000D0);
    for (int i = 0; i < 6; i++) begin
      cnt = (i == 0) ? 9'h005 : 9'h1FF;
      p = {nxt(), nxt(), nxt()};
      p = $signed(p) >>> rnd[5:0];
      {iss.a, iss.b} = p;
      iss.x = 24'(nxt());
      run_op(mk(`RNC_OP_LEFT, {3'h1, 3'h0, cnt}), {2'b01, 3'h0, cnt});
      ex = normalize_count_down(p, int'(cnt), iss.x);
      check({res.a, res.b}, ex[71:24]);
      check(res.x, ex[23:0]);
      check({res.ab_we, res.x_we}, 2'b11);
      check(took, 24'(iss.x - ex[23:0]) + 2);
    end
    run_op(mk(`RNC_OP_LEFT, 15'h0005), 14'h0005);
    check(res.act, rnc_pkg::RNC_ACT_FOREIGN);
    $display("normalize test done");
    for (int i = 0; i < 10; i++) begin
      sel = (i < 4) ? 4'(1 << i) : 4'(nxt());
      sel = (sel == 4'h0) ? 4'h9 : sel;
      bpt = 4'(nxt());
      w = mk(`RNC_OP_SKS,
             15'h2000 | {6'h0, sel[0], sel[1], sel[2], sel[3], 5'h0});
      run_op(w, 14'h0);
      check(res.act, (|(sel & ~bpt)) ? 1 : 0);
    end
    md = rnc_pkg::RNC_MODE_USER;
    run_op(w, 14'h0);
    check({res.act, res.next_pc}, {3'h2, `RNC_TRAP_ADDR});
    check(res.save_pc, iss.pc);
    run_op(24'h000000, 14'h0);
    check({res.act, res.next_pc}, {3'h2, `RNC_TRAP_ADDR});
    check({halt_lamp_o, res.save_pc}, {1'b0, iss.pc});
    md = rnc_pkg::RNC_MODE_NORMAL;
    run_op(24'h000000, 14'h0);
    check({res.act, res.next_pc}, {3'h4, 14'(iss.pc + 14'h1)});
    repeat (4) @(negedge clk_i);
    check({halt_lamp_o, issue_ready_o, resume_o}, 3'b100);
    sw = rnc_pkg::RNC_SW_IDLE;
    repeat (3) @(negedge clk_i);
    sw = rnc_pkg::RNC_SW_STEP;
    wait_resume();
    check({halt_lamp_o, resume_irq_o}, 2'b00);
    sw = rnc_pkg::RNC_SW_RUN;
    run_op(24'h000000, 14'h0);
    irq = 1'b1;
    wait_resume();
    check({halt_lamp_o, resume_irq_o}, 2'b01);
    irq = 1'b0;
    $display("halt test done");
    run_op(mk(`RNC_OP_EXU, 15'h0001), 14'h0001);
    check({res.act, res.next_pc}, {3'h1, iss.pc + 14'h0002});
    lat = 4'h3;
    run_op(mk(`RNC_OP_EXU, 15'h0004), 14'h0004);
    check({res.act, res.save_pc}, {3'h3, iss.pc});
    run_op(mk(`RNC_OP_EXU, 15'h0005), 14'h0005);
    check({res.act, res.next_pc}, {3'h0, iss.pc + 14'h0001});
    md = rnc_pkg::RNC_MODE_USER;
    run_op(mk(`RNC_OP_EXU, 15'h0002), 14'h0002);
    check({res.act, res.save_pc}, {3'h2, iss.pc});
    md = rnc_pkg::RNC_MODE_MONITOR;
    irq = 1'b1;
    run_op(mk(`RNC_OP_EXU, 15'h0002), 14'h0002);
    check({res.act, res.save_pc}, {3'h5, iss.pc});
    irq = 1'b0;
    $display("execute test done");
    test_done();
  end
endmodule
